// ### hw/vitb_pkg.sv
/*
 Constants, register map and vector table of the vectored interrupt
 controller with its tick generator.
 Assumes a single 125 MHz clock and an APB master with 32-bit data.
*/
// Function
// - Master enable clear blocks accepting a request; a jump already accepted still follows.
// - Timer overflow, tick or pin edge sets its flag; only enabled ones request.
// - On the jump push next instruction address and load the winner's vector in the same cycle.
// - Return-from-interrupt pops the saved program counter.
// - Service clears master enable and the serviced request flag.
// - Requests during service still set and hold their flags.
// - Software setting master enable in service allows nesting.
// - Stack full blocks acknowledging any request.
// - Jump comes 2 instruction cycles after request, 3 after wake-up.
// - Requests between two second-phase pulses are serviced on the later.
// - Three sources: pin 04H, timer 0 08H, tick 0CH, in that order.
// - Four sources: pin, timer 0, timer 1 at 0CH, tick at 10H.
// - External request wins over simultaneous internal requests.
// - Edge select bits 7:6: off, rising, falling, both edges.
// - Pin acts only with enable set, edge chosen and direction input.
// - Three-source control: flags 6..4, enables 3..1, master bit 0, bit 7 zero.
// - Tick uses a 13-stage divider, two-bit tap select, timer 0 source bit.
// - Each tick timeout sets the tick request flag.
// - A flag stays set while disabled until serviced or cleared by software.
// - Every source can wake the processor from idle or sleep.
package vitb_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_IRQ_CTL0 = 8'h00;
  localparam logic [7:0] ADDR_IRQ_CTL1 = 8'h04;
  localparam logic [7:0] ADDR_SYSCTL1 = 8'h08;
  localparam logic [7:0] ADDR_TIMER0_CTL = 8'h0C;
  localparam logic [7:0] ADDR_PADIR = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // ==========================================================
  // Field positions
  localparam int BIT_MASTER_EN = 0;
  localparam int BIT_EN_LO = 1;
  localparam int BIT_FLAG_LO = 4;
  localparam int BIT_CTL1_EN = 0;
  localparam int BIT_CTL1_FLAG = 4;
  localparam int BIT_EDGE_LO = 6;
  localparam int BIT_DIV_LO = 4;
  localparam int BIT_T0_SRC = 3;
  localparam int BIT_PIN_DIR = 3;

  // ==========================================================
  // Sources, in priority order
  localparam int NSRC = 4;
  localparam int SRC_EXT = 0;
  localparam int SRC_T0 = 1;
  localparam int SRC_T1 = 2;
  localparam int SRC_TICK = 3;
  localparam logic [3:0] SRC_MASK3 = 4'hB;
  localparam logic [3:0] SRC_MASK4 = 4'hF;

  localparam logic [7:0] VEC_EXT = 8'h04;
  localparam logic [7:0] VEC_T0 = 8'h08;
  localparam logic [7:0] VEC_T1 = 8'h0C;
  localparam logic [7:0] VEC_TICK3 = 8'h0C;
  localparam logic [7:0] VEC_TICK4 = 8'h10;

  // ==========================================================
  // Edge select codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ==========================================================
  // Timing
  localparam int SYS_CLK_MHZ = 125;
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] PHASE_TWO_SLOT = 2'h1;
  localparam logic [1:0] LAT_NORMAL = 2'h2;
  localparam logic [1:0] LAT_WAKE = 2'h3;
  localparam int TICK_STAGES = 13;
  localparam int TICK_TAP_BASE = 10;

  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_WAIT = 1'b1
  } vitb_seq_t;

endpackage

// ### hw/vitb_ctrl.sv
/*
 Vectored interrupt controller with tick generator: request flags, enables,
 fixed priority, push/vector/pop handshake with the core, APB registers.
 Assumes the core acts on the one-cycle push, load and pop pulses, and that
 timer overflows and the alternate tick source are enables on SYS_CLK.
*/
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module vitb_ctrl #(
  parameter int PC_W = 11,
  parameter bit FOUR_SRC = 1'b0
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Event sources
  input wire logic PORT_A_LINE_THREE,
  input wire logic TIMER0_OVF,
  input wire logic TIMER1_OVF,
  input wire logic TICK_ALT_EN,
  // Core sequencer
  input wire logic [PC_W-1:0] CORE_NEXT_PC,
  input wire logic CORE_STACK_FULL,
  input wire logic CORE_SLEEP,
  input wire logic CORE_RETURN_FROM_INTERRUPT,
  output logic STACK_PUSH,
  output logic [PC_W-1:0] STACK_PUSH_PC,
  output logic PC_LOAD,
  output logic [PC_W-1:0] PC_VECTOR,
  output logic STACK_POP,
  output logic WAKE_REQ,
  output logic SECOND_CLOCK_PHASE
);
  import vitb_pkg::*;

  // ==========================================================
  // Elaboration check
  if (PC_W < 8 || PC_W > 16) begin : g_bad_pc_w
    $error("PC_W must lie in 8..16");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0] phase;
    logic ph2;
    logic [NSRC-1:0] flag;
    logic [NSRC-1:0] ena;
    logic master_en;
    logic [1:0] edge_sel;
    logic [1:0] div_sel;
    logic t0_src;
    logic pin_dir;
    logic [TICK_STAGES-1:0] div_cnt;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    vitb_seq_t seq;
    logic [1:0] lat;
    logic [1:0] win;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic push;
    logic [PC_W-1:0] push_pc;
    logic pc_load;
    logic [PC_W-1:0] vec;
    logic pop;
    logic wake;
  } vitb_state_t;

  vitb_state_t s_q;
  vitb_state_t s_d;

  logic [NSRC-1:0] present;
  logic [NSRC-1:0] elig;
  logic [NSRC-1:0] hw_set;
  logic [NSRC-1:0] svc_clr;
  logic [1:0] pick;
  logic any_elig;
  logic pin_edge;
  logic pin_live;
  logic tick_src;
  logic tick_out;
  logic accept;
  logic jump;
  logic wr;
  logic [7:0] wb;
  logic [7:0] rd_ctl0;
  logic [7:0] rd_ctl1;
  logic [7:0] vec_pick;
  logic [TICK_STAGES:0] tap_mask;

  assign present = FOUR_SRC ? SRC_MASK4 : SRC_MASK3;

  // ==========================================================
  // Fixed priority: lowest index wins, the pin is index zero
  always_comb begin
    pick = 2'h0;
    any_elig = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (elig[i]) begin
        pick = 2'(i);
        any_elig = 1'b1;
      end
    end
  end

  always_comb begin
    case (s_q.win)
      2'(SRC_EXT): vec_pick = VEC_EXT;
      2'(SRC_T0): vec_pick = VEC_T0;
      2'(SRC_T1): vec_pick = VEC_T1;
      2'(SRC_TICK): vec_pick = FOUR_SRC ? VEC_TICK4 : VEC_TICK3;
      default: vec_pick = VEC_EXT;
    endcase
  end

  always_comb begin
    if (FOUR_SRC) begin
      rd_ctl0 = {1'b0, s_q.flag[SRC_T1], s_q.flag[SRC_T0], s_q.flag[SRC_EXT],
                 s_q.ena[SRC_T1], s_q.ena[SRC_T0], s_q.ena[SRC_EXT], s_q.master_en};
      rd_ctl1 = {3'h0, s_q.flag[SRC_TICK], 3'h0, s_q.ena[SRC_TICK]};
    end else begin
      // Bit 7 is unimplemented and reads zero
      rd_ctl0 = {1'b0, s_q.flag[SRC_TICK], s_q.flag[SRC_T0], s_q.flag[SRC_EXT],
                 s_q.ena[SRC_TICK], s_q.ena[SRC_T0], s_q.ena[SRC_EXT], s_q.master_en};
      rd_ctl1 = 8'h00;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    wb = PWDATA[7:0];
    wr = PSEL & PENABLE & PWRITE & s_q.pready;

    // Instruction clock divider; the phase-two pulse paces arbitration
    s_d.phase = 2'(s_q.phase + 2'h1);
    s_d.ph2 = (s_q.phase == PHASE_TWO_SLOT);

    // Pin synchroniser; only the second stage feeds the edge detector
    s_d.pin_s1 = PORT_A_LINE_THREE;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_prev = s_q.pin_s2;
    pin_live = s_q.ena[SRC_EXT] & (s_q.edge_sel != EDGE_OFF) & s_q.pin_dir;
    case (s_q.edge_sel)
      EDGE_RISE: pin_edge = s_q.pin_s2 & ~s_q.pin_prev;
      EDGE_FALL: pin_edge = ~s_q.pin_s2 & s_q.pin_prev;
      EDGE_BOTH: pin_edge = s_q.pin_s2 ^ s_q.pin_prev;
      default: pin_edge = 1'b0;
    endcase

    // Tick generator: 13 stages, tap chosen by divide select
    tick_src = s_q.t0_src ? TICK_ALT_EN : s_q.ph2;
    tap_mask = 14'((14'h1 << (TICK_TAP_BASE + int'(s_q.div_sel))) - 14'h1);
    tick_out = tick_src &
               ((s_q.div_cnt & tap_mask[TICK_STAGES-1:0]) == tap_mask[TICK_STAGES-1:0]);
    if (tick_src) begin
      s_d.div_cnt = 13'(s_q.div_cnt + 13'h1);
    end

    hw_set = '0;
    hw_set[SRC_EXT] = pin_live & pin_edge;
    hw_set[SRC_T0] = TIMER0_OVF;
    hw_set[SRC_T1] = TIMER1_OVF & FOUR_SRC;
    hw_set[SRC_TICK] = tick_out;

    // Arbitration happens only on phase-two pulses, so anything that
    // arrived since the last pulse is weighed together
    elig = s_q.flag & s_q.ena & present;
    accept = s_q.ph2 & s_q.master_en & any_elig & ~CORE_STACK_FULL &
             (s_q.seq == SEQ_IDLE);
    svc_clr = '0;
    jump = 1'b0;

    s_d.push = 1'b0;
    s_d.pc_load = 1'b0;
    s_d.pop = CORE_RETURN_FROM_INTERRUPT;

    case (s_q.seq)
      SEQ_IDLE: begin
        if (accept) begin
          s_d.win = pick;
          // Counts whole phase-two pulses after the accepting one, so that
          // a request waits 2 to 3 instruction cycles, 3 to 4 from sleep
          s_d.lat = CORE_SLEEP ? LAT_WAKE : LAT_NORMAL;
          s_d.seq = SEQ_WAIT;
          svc_clr[pick] = 1'b1;
        end
      end
      SEQ_WAIT: begin
        if (s_q.ph2) begin
          if (s_q.lat == 2'h1) begin
            jump = 1'b1;
            s_d.seq = SEQ_IDLE;
          end else begin
            s_d.lat = 2'(s_q.lat - 2'h1);
          end
        end
      end
      default: s_d.seq = SEQ_IDLE;
    endcase

    if (jump) begin
      s_d.push = 1'b1;
      s_d.push_pc = CORE_NEXT_PC;
      s_d.pc_load = 1'b1;
      s_d.vec = PC_W'(vec_pick);
    end

    // Software writes first, then service clear, then hardware sets win
    if (wr) begin
      case (PADDR)
        ADDR_IRQ_CTL0: begin
          s_d.master_en = wb[BIT_MASTER_EN];
          s_d.flag[SRC_EXT] = wb[BIT_FLAG_LO];
          s_d.flag[SRC_T0] = wb[BIT_FLAG_LO+1];
          s_d.ena[SRC_EXT] = wb[BIT_EN_LO];
          s_d.ena[SRC_T0] = wb[BIT_EN_LO+1];
          if (FOUR_SRC) begin
            s_d.flag[SRC_T1] = wb[BIT_FLAG_LO+2];
            s_d.ena[SRC_T1] = wb[BIT_EN_LO+2];
          end else begin
            s_d.flag[SRC_TICK] = wb[BIT_FLAG_LO+2];
            s_d.ena[SRC_TICK] = wb[BIT_EN_LO+2];
          end
        end
        ADDR_IRQ_CTL1: begin
          if (FOUR_SRC) begin
            s_d.flag[SRC_TICK] = wb[BIT_CTL1_FLAG];
            s_d.ena[SRC_TICK] = wb[BIT_CTL1_EN];
          end
        end
        ADDR_SYSCTL1: begin
          s_d.edge_sel = wb[BIT_EDGE_LO+1:BIT_EDGE_LO];
          s_d.div_sel = wb[BIT_DIV_LO+1:BIT_DIV_LO];
        end
        ADDR_TIMER0_CTL: s_d.t0_src = wb[BIT_T0_SRC];
        ADDR_PADIR: s_d.pin_dir = wb[BIT_PIN_DIR];
        default: s_d.master_en = s_d.master_en;
      endcase
    end
    if (accept) begin
      s_d.master_en = 1'b0;
    end
    s_d.flag = (s_d.flag & ~svc_clr) | hw_set;

    // Any pending flag wakes the core, whatever its enable
    s_d.wake = |(s_d.flag & present);

    // APB: no wait state, data latched in the setup cycle
    // Error flop lives only in the access cycle, so the pin needs no gate
    s_d.pready = PSEL & ~PENABLE;
    s_d.pslverr = 1'b0;
    if (PSEL & ~PENABLE) begin
      s_d.prdata = 32'h0;
      case (PADDR)
        ADDR_IRQ_CTL0: s_d.prdata = {24'h0, rd_ctl0};
        ADDR_IRQ_CTL1: s_d.prdata = {24'h0, rd_ctl1};
        ADDR_SYSCTL1: s_d.prdata = {24'h0, s_q.edge_sel, s_q.div_sel, 4'h0};
        ADDR_TIMER0_CTL: s_d.prdata = {28'h0, s_q.t0_src, 3'h0};
        ADDR_PADIR: s_d.prdata = {28'h0, s_q.pin_dir, 3'h0};
        ADDR_STATUS: s_d.prdata = {26'h0, s_q.pin_s2, s_q.wake, s_q.win,
                                   s_q.lat == 2'h0, s_q.seq == SEQ_WAIT};
        default: s_d.pslverr = 1'b1;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.seq <= SEQ_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs, all straight from state flops
  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;
  assign STACK_PUSH = s_q.push;
  assign STACK_PUSH_PC = s_q.push_pc;
  assign PC_LOAD = s_q.pc_load;
  assign PC_VECTOR = s_q.vec;
  assign STACK_POP = s_q.pop;
  assign WAKE_REQ = s_q.wake;
  assign SECOND_CLOCK_PHASE = s_q.ph2;

endmodule // vitb_ctrl

// ### tb/vitb_ctrl_assertions.sv
/* Port checker for the interrupt controller, bound to every instance.
   Assumes the three-source build and a single clock domain. */
`timescale 1ns/100ps
module vitb_ctrl_assertions #(
  parameter int PC_W = 11
) (
  // Clock, reset and bus
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Core side
  input wire logic CORE_STACK_FULL,
  input wire logic CORE_RETURN_FROM_INTERRUPT,
  input wire logic STACK_PUSH,
  input wire logic [PC_W-1:0] STACK_PUSH_PC,
  input wire logic PC_LOAD,
  input wire logic [PC_W-1:0] PC_VECTOR,
  input wire logic STACK_POP,
  input wire logic SECOND_CLOCK_PHASE
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // Full-stack age; a counter, since the wait is too long to unroll
  logic [4:0] full_q;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) full_q <= 5'h00;
    else if (!CORE_STACK_FULL) full_q <= 5'h00;
    else if (full_q != 5'h1F) full_q <= full_q + 5'h01;
  end
  sequence ph2_gap;
    !SECOND_CLOCK_PHASE [*3] ##1 SECOND_CLOCK_PHASE;
  endsequence
  // ==========================================================
  a_push_with_load: assert property (STACK_PUSH == PC_LOAD)
    else $error("push and load differ");
  a_load_after_phase: assert property (PC_LOAD |-> $past(SECOND_CLOCK_PHASE))
    else $error("load not after phase two");
  a_load_single: assert property (PC_LOAD |=> !PC_LOAD)
    else $error("load longer than one cycle");
  a_vector_legal: assert property (PC_LOAD |-> PC_VECTOR[7:0] inside {8'h04, 8'h08, 8'h0C})
    else $error("illegal vector");
  a_vector_hold: assert property (!PC_LOAD |-> $stable(PC_VECTOR) && $stable(STACK_PUSH_PC))
    else $error("vector moved without load");
  a_pop_follows: assert property (CORE_RETURN_FROM_INTERRUPT |=> STACK_POP)
    else $error("no pop after return");
  a_pop_cause: assert property (STACK_POP |-> $past(CORE_RETURN_FROM_INTERRUPT))
    else $error("pop without return");
  a_phase_period: assert property (SECOND_CLOCK_PHASE |=> ph2_gap)
    else $error("phase two period wrong");
  a_full_blocks: assert property (full_q > 5'h0F |-> !PC_LOAD)
    else $error("jump while stack full");
  a_apb_ready: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready in access");
  a_err_gated: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("error outside access");
endmodule // vitb_ctrl_assertions
bind vitb_ctrl vitb_ctrl_assertions #(.PC_W(PC_W)) u_chk (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .CORE_STACK_FULL(CORE_STACK_FULL),
  .CORE_RETURN_FROM_INTERRUPT(CORE_RETURN_FROM_INTERRUPT),
  .STACK_PUSH(STACK_PUSH), .STACK_PUSH_PC(STACK_PUSH_PC), .PC_LOAD(PC_LOAD),
  .PC_VECTOR(PC_VECTOR), .STACK_POP(STACK_POP),
  .SECOND_CLOCK_PHASE(SECOND_CLOCK_PHASE));

// ### tb/vitb_core_model.sv
/* Core sequencer model: program counter and a small return stack.
   Assumes one-cycle push, load and pop pulses from the controller. */
`timescale 1ns/100ps
module vitb_core_model #(
  parameter int PC_W = 11,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Controller side
  input wire logic push,
  input wire logic [PC_W-1:0] push_pc,
  input wire logic load,
  input wire logic [PC_W-1:0] vector,
  input wire logic pop,
  output logic [PC_W-1:0] next_pc,
  output logic full,
  output logic ret,
  // Bench side
  input wire logic ret_req
);
  logic [PC_W-1:0] stk[$];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stk.delete();
      next_pc <= PC_W'(8'h20);
      full <= 1'b0;
      ret <= 1'b0;
    end else begin
      ret <= ret_req;
      if (push) stk.push_back(push_pc);
      if (load) next_pc <= vector + 1'b1;
      if (pop) next_pc <= stk.pop_back();
      full <= stk.size() >= DEPTH;
    end
  end
endmodule // vitb_core_model

// ### tb/test_vectored_irq_controller_timebase.sv
/* Self-checking bench for the interrupt controller and tick divider.
   Assumes the three-source build and a two-deep core stack model. */
`timescale 1ns/100ps
module test_vectored_irq_controller_timebase;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, pin, t0, talt, sleep;
  logic push, load, pop, wake, ph2, full, ret, ret_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [10:0] ppc, vec, npc;
  logic [7:0] q;
  logic qerr;
  int fail_count, checks, loads, exp_c0, l0, l1, c, n;
  int seed = 32'h1855;
  int exp_stk[$];
  vitb_ctrl #(.PC_W(11), .FOUR_SRC(1'b0)) u_dut (.SYS_CLK(clk), .RST_N(rst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PORT_A_LINE_THREE(pin),
    .TIMER0_OVF(t0), .TIMER1_OVF(1'b0), .TICK_ALT_EN(talt), .CORE_NEXT_PC(npc),
    .CORE_STACK_FULL(full), .CORE_SLEEP(sleep), .CORE_RETURN_FROM_INTERRUPT(ret),
    .STACK_PUSH(push), .STACK_PUSH_PC(ppc), .PC_LOAD(load), .PC_VECTOR(vec),
    .STACK_POP(pop), .WAKE_REQ(wake), .SECOND_CLOCK_PHASE(ph2));
  vitb_core_model #(.PC_W(11), .DEPTH(2)) u_core (.clk(clk), .rst_n(rst_n),
    .push(push), .push_pc(ppc), .load(load), .vector(vec), .pop(pop),
    .next_pc(npc), .full(full), .ret(ret), .ret_req(ret_req));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (load === 1'b1) loads++;
  // ==========================================================
  task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    q = prdata[7:0];
    qerr = pslverr;
    ck("ready", 32'h1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never re-drives psel in this step
    @(posedge clk);
  endtask
  task automatic jump(input logic [7:0] ev, output int lat);
    lat = 0;
    while (load !== 1'b1 && lat < 40) begin
      @(posedge clk);
      lat++;
    end
    ck("load seen", 32'h1, {31'h0, load});
    ck("vector", ev, vec);
    ck("push pc", npc, ppc);
    exp_stk.push_back(npc);
  endtask
  task automatic svc(output int lat);
    int w;
    w = 0;
    while (!(exp_c0[4+w] && exp_c0[1+w])) w++;
    while (ph2 !== 1'b1) @(posedge clk);
    apb(1'b1, 8'h00, 8'(exp_c0 | 1));
    jump(8'(4 * w + 4), lat);
    exp_c0 = exp_c0 & ~(1 | (16 << w));
    apb(1'b0, 8'h00, 8'h00);
    ck("control after jump", exp_c0, q);
  endtask
  task automatic ret_irq;
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    repeat (3) @(posedge clk);
    ck("resume pc", exp_stk.pop_back(), npc);
  endtask
  task automatic results;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #(8 * 20000);
    fail_count++;
    results;
  end
  // ==========================================================
  initial begin
    {psel, penable, pwrite, pin, t0, talt, sleep, ret_req} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 5; a++) begin
      apb(1'b0, 8'(a * 4), 8'h00);
      ck("reset value", 32'h00, q);
      ck("mapped error", 32'h0, {31'h0, qerr});
    end
    apb(1'b0, 8'h18, 8'h00);
    ck("unmapped read", 32'h00, q);
    ck("unmapped error", 32'h1, {31'h0, qerr});
    $display("reset test done");
    repeat (4) begin
      c = $random(seed) & 8'hFE;
      apb(1'b1, 8'h00, 8'(c));
      repeat (12) @(posedge clk);
      apb(1'b0, 8'h00, 8'h00);
      ck("software write", c & 8'h7E, q);
    end
    ck("no jump masked", 32'h00, loads);
    apb(1'b1, 8'h00, 8'h01);
    t0 <= 1'b1;
    @(posedge clk);
    t0 <= 1'b0;
    repeat (16) @(posedge clk);
    apb(1'b0, 8'h00, 8'h00);
    ck("disabled flag held", 32'h21, q);
    ck("disabled no jump", 32'h00, loads);
    ck("wake on masked flag", 32'h1, {31'h0, wake});
    $display("mask test done");
    exp_c0 = 8'h7E;
    apb(1'b1, 8'h00, 8'h7E);
    for (int i = 0; i < 3; i++) begin
      svc(l0);
      ret_irq;
    end
    sleep <= 1'b1;
    exp_c0 = 8'h12;
    svc(l1);
    ret_irq;
    sleep <= 1'b0;
    exp_c0 = 8'h12;
    svc(l0);
    ret_irq;
    ck("wake latency step", 32'd4, l1 - l0);
    $display("priority test done");
    exp_c0 = 8'h36;
    svc(l0);
    svc(l0);
    exp_c0 = exp_c0 | 8'h49;
    c = loads;
    apb(1'b1, 8'h00, 8'(exp_c0));
    repeat (40) @(posedge clk);
    ck("full blocks jump", c, loads);
    ret_irq;
    jump(8'h0C, l0);
    ret_irq;
    ret_irq;
    $display("nesting test done");
    for (int k = 0; k < 6; k++) begin
      c = (k < 4) ? k : 3;
      n = (k == 5) ? 0 : 2;
      apb(1'b1, 8'h10, (k == 4) ? 8'h00 : 8'h08);
      apb(1'b1, 8'h00, 8'(n));
      apb(1'b1, 8'h08, 8'(c << 6));
      for (int e = 0; e < 2; e++) begin
        pin <= !pin;
        repeat (8) @(posedge clk);
        apb(1'b0, 8'h00, 8'h00);
        ck("edge flag", n | ((c[e] && k < 4) ? 16 : 0), q);
        apb(1'b1, 8'h00, 8'(n));
      end
    end
    $display("edge test done");
    apb(1'b1, 8'h0C, 8'h08);
    talt <= 1'b1;
    // Two divide taps; each run first locks onto a tick, then times the next
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, 8'h08, 8'(s << 4));
      apb(1'b1, 8'h00, 8'h00);
      n = 0;
      while (wake !== 1'b1 && n < 2200) begin
        @(posedge clk);
        n++;
      end
      apb(1'b1, 8'h00, 8'h00);
      n = 3;
      while (wake !== 1'b1 && n < 2200) begin
        @(posedge clk);
        n++;
      end
      ck("tick period", 32'd1024 << s, n);
    end
    $display("tick test done");
    results;
  end
endmodule // test_vectored_irq_controller_timebase
